// *** common/smc_pkg.sv ***
// Package of constants and types for the card host control and status block
package smc_pkg;
  localparam int          FIFO_DEPTH      = 64;
  localparam int          FIFO_AW         = 6;
  localparam logic [6:0]  FIFO_CNT_RST    = 7'h00;
  localparam logic [7:0]  CLK_DIV_RST     = 8'h00;
  localparam logic [7:0]  RSP_TO_RST      = 8'h00;
  localparam logic [15:0] RD_TO_RST       = 16'h0000;
  localparam logic [11:0] BLK_LEN_RST     = 12'h200;
  localparam logic [15:0] BLK_CNT_RST     = 16'h0000;
  localparam logic [6:0]  FIFO_LEV_RST    = 7'h20;
  localparam logic [9:0]  IRQ_MASK_RST    = 10'h000;
  // Interrupt flag positions in the first status register
  localparam int ST_TX_RDY   = 0;
  localparam int ST_RX_RDY   = 1;
  localparam int ST_CRC_RSP  = 2;
  localparam int ST_CRC_RD   = 3;
  localparam int ST_CRC_WR   = 4;
  localparam int ST_TO_RSP   = 5;
  localparam int ST_TO_RD    = 6;
  localparam int ST_RSP_DONE = 7;
  localparam int ST_BSY_DONE = 8;
  localparam int ST_BLK_DONE = 9;
  localparam int ST_W        = 10;
  typedef enum logic [1:0] {
    SMC_IDLE = 2'b00,
    SMC_RSP  = 2'b01,
    SMC_RD   = 2'b10,
    SMC_BUSY = 2'b11
  } smc_state_e;
endpackage

// *** hw/smc_fifo_mem.sv ***
// Byte-wide shared transfer memory with registered read data
`timescale 1ns/100ps
module smc_fifo_mem (
  input  wire logic                       clk,
  input  wire logic                       wr_en,
  input  wire logic [smc_pkg::FIFO_AW-1:0] wr_addr,
  input  wire logic [7:0]                 wr_data,
  input  wire logic [smc_pkg::FIFO_AW-1:0] rd_addr,
  output logic      [7:0]                 rd_data
);
  import smc_pkg::*;
  logic [7:0] mem [FIFO_DEPTH];
  // No reset on the array: contents are don't-care until written
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// *** hw/smc_clk_div.sv ***
// Memory clock divider producing card clock level and rising-edge enable
`timescale 1ns/100ps
module smc_clk_div (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       run,
  input  wire logic [7:0] div_value,
  input  wire logic       divide_by_four_select_sel,
  output logic            card_clk,
  output logic            rise_en
);
  import smc_pkg::*;
  logic [8:0] cnt_reg;
  logic [8:0] limit;
  wire        half_done;
  // Half period is (value+1) or 2*(value+1) function clocks
  assign limit = divide_by_four_select_sel ? {div_value, 1'b1} : {1'b0, div_value};
  assign half_done = (cnt_reg >= limit);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg  <= 9'h000;
      card_clk <= 1'b0;
      rise_en  <= 1'b0;
    end else if (!run) begin
      cnt_reg  <= 9'h000;
      card_clk <= 1'b0;
      rise_en  <= 1'b0;
    end else if (half_done) begin
      cnt_reg  <= 9'h000;
      card_clk <= ~card_clk;
      rise_en  <= ~card_clk;
    end else begin
      cnt_reg  <= cnt_reg + 9'h001;
      rise_en  <= 1'b0;
    end
  end
endmodule

// *** hw/smc_ctrl.sv ***
// Card host control and status: write path, clocking, time-outs, flags
`timescale 1ns/100ps
module smc_ctrl (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  soft_reset,
  input  wire logic                  cmd_logic_reset,
  input  wire logic                  data_logic_reset,
  input  wire logic                  bus_width_4,
  input  wire logic                  card_clock_out_enable,
  input  wire logic [7:0]            clock_divider_value,
  input  wire logic                  divide_by_four_select,
  input  wire logic [smc_pkg::ST_W-1:0] interrupt_mask_reg,
  input  wire logic [7:0]            response_timeout_reg,
  input  wire logic [15:0]           read_data_timeout_reg,
  input  wire logic [11:0]           block_length_reg,
  input  wire logic [15:0]           block_count_reg,
  input  wire logic [6:0]            fifo_threshold_level,
  input  wire logic                  fifo_dir_write,
  input  wire logic                  tx_data_wr,
  input  wire logic [3:0]            tx_data_be,
  input  wire logic [31:0]           tx_data_reg,
  input  wire logic                  rx_data_rd,
  input  wire logic                  status_reg_a_rd,
  input  wire logic                  cmd_start,
  input  wire logic                  cmd_needs_rsp,
  input  wire logic                  expect_busy_bit,
  input  wire logic                  cmd_sent,
  input  wire logic                  rsp_received,
  input  wire logic                  rsp_crc_err,
  input  wire logic                  rd_start,
  input  wire logic                  rd_first_data,
  input  wire logic                  rd_crc_err,
  input  wire logic                  wr_crc_err,
  input  wire logic                  card_byte_in_valid,
  input  wire logic [7:0]            card_byte_in,
  input  wire logic                  card_byte_out_take,
  input  wire logic                  card_busy_in,
  input  wire logic                  stop_transmission,
  output logic                       card_clock_pin,
  output logic                       card_bus_4bit,
  output logic [7:0]                 card_byte_out,
  output logic                       tx_ready_irq,
  output logic [smc_pkg::ST_W-1:0]   status_reg_a,
  output logic                       card_busy_flag,
  output logic [6:0]                 fifo_level,
  output logic [15:0]                blocks_left,
  output logic                       xfer_active,
  output logic                       mmc_irq
);
  import smc_pkg::*;

  smc_state_e             state_reg;
  smc_state_e             state_next;
  logic [ST_W-1:0]        flags_reg;
  logic [ST_W-1:0]        flags_set;
  logic [6:0]             count_reg;
  logic [FIFO_AW-1:0]     wptr_reg;
  logic [FIFO_AW-1:0]     rptr_reg;
  logic [1:0]             lane_reg;
  logic [3:0]             pend_be_reg;
  logic [31:0]            pend_data_reg;
  logic [15:0]            to_cnt_reg;
  logic [11:0]            byte_cnt_reg;
  logic [15:0]            blk_left_reg;
  logic                   busy_seen_reg;
  logic                   mem_wr;
  logic [FIFO_AW-1:0]     mem_waddr;
  logic [7:0]             mem_wdata;
  logic [7:0]             mem_rdata;
  logic                   div_clk;
  logic                   clk_rise;
  logic [1:0]             lane_sel;
  logic                   lane_valid;

  wire cmd_rst   = cmd_logic_reset;
  wire data_rst  = data_logic_reset;
  wire any_xfer  = (state_reg != SMC_IDLE) || (count_reg != 7'h00);
  wire clk_run   = card_clock_out_enable || any_xfer;
  wire buf_full  = (count_reg == 7'(FIFO_DEPTH));
  wire cpu_push  = fifo_dir_write && lane_valid && !buf_full;
  wire card_push = !fifo_dir_write && card_byte_in_valid && !buf_full
                   && !data_rst;
  wire push      = cpu_push || card_push;
  wire pop       = (card_byte_out_take || rx_data_rd) && (count_reg != 0)
                   && !data_rst;
  wire to_rsp_hit = (response_timeout_reg != 8'h00)
                    && (to_cnt_reg[7:0] == response_timeout_reg);
  wire to_rd_hit  = (read_data_timeout_reg != 16'h0000)
                    && (to_cnt_reg == read_data_timeout_reg);
  wire blk_end    = card_push && (byte_cnt_reg == block_length_reg - 12'h1);
  wire last_blk   = (block_count_reg != 16'h0000)
                    && (blk_left_reg == 16'h0001);

  // Lowest pending byte lane goes first, little-endian order
  function automatic logic [1:0] first_lane(input logic [3:0] be);
    first_lane = be[0] ? 2'd0 : be[1] ? 2'd1 : be[2] ? 2'd2 : 2'd3;
  endfunction

  assign lane_sel   = first_lane(pend_be_reg);
  assign lane_valid = (pend_be_reg != 4'h0);
  assign mem_wr     = push;
  assign mem_waddr  = wptr_reg;
  assign mem_wdata  = cpu_push ? pend_data_reg[8*lane_sel +: 8]
                               : card_byte_in;

  smc_fifo_mem u_mem (
    .clk     (clk),
    .wr_en   (mem_wr),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_addr (rptr_reg),
    .rd_data (mem_rdata)
  );

  smc_clk_div u_div (
    .clk       (clk),
    .reset_n   (reset_n),
    .run       (clk_run),
    .div_value (clock_divider_value),
    .divide_by_four_select_sel  (divide_by_four_select),
    .card_clk  (div_clk),
    .rise_en   (clk_rise)
  );

  // Command and read-wait sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SMC_IDLE: begin
        if (cmd_start && !cmd_rst) begin
          state_next = cmd_needs_rsp ? SMC_RSP
                     : (expect_busy_bit ? SMC_BUSY : SMC_IDLE);
        end else if (rd_start && !data_rst) begin
          state_next = SMC_RD;
        end
      end
      SMC_RSP: begin
        if (rsp_received || to_rsp_hit) begin
          state_next = expect_busy_bit && rsp_received ? SMC_BUSY : SMC_IDLE;
        end
      end
      SMC_RD: begin
        if (rd_first_data || to_rd_hit) begin
          state_next = SMC_IDLE;
        end
      end
      SMC_BUSY: begin
        if (busy_seen_reg && !card_busy_in) begin
          state_next = SMC_IDLE;
        end
      end
      default: state_next = SMC_IDLE;
    endcase
  end

  // Hardware events that set sticky flags
  always_comb begin
    flags_set = '0;
    flags_set[ST_TX_RDY]   = fifo_dir_write
                             && (count_reg < fifo_threshold_level);
    flags_set[ST_RX_RDY]   = !fifo_dir_write
                             && (count_reg > fifo_threshold_level);
    flags_set[ST_CRC_RSP]  = rsp_crc_err;
    flags_set[ST_CRC_RD]   = rd_crc_err;
    flags_set[ST_CRC_WR]   = wr_crc_err;
    // The hit already counts card clock edges, and the sequencer leaves
    // the waiting state in the same cycle, so no edge qualifier here
    flags_set[ST_TO_RSP]   = (state_reg == SMC_RSP) && to_rsp_hit
                             && !rsp_received;
    flags_set[ST_TO_RD]    = (state_reg == SMC_RD) && to_rd_hit
                             && !rd_first_data;
    flags_set[ST_RSP_DONE] = (state_reg == SMC_RSP && rsp_received)
                             || (state_reg == SMC_IDLE && cmd_sent
                                 && !cmd_needs_rsp);
    flags_set[ST_BSY_DONE] = (state_reg == SMC_BUSY)
                             && !card_busy_in;
    flags_set[ST_BLK_DONE] = blk_end && last_blk;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= SMC_IDLE;
    end else if (cmd_rst || stop_transmission) begin
      state_reg <= SMC_IDLE;
    end else if (!soft_reset) begin
      state_reg <= state_next;
    end
  end

  // Time-out counter counts card clock rising edges in a waiting state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      to_cnt_reg <= 16'h0000;
    end else if (state_reg != state_next || state_reg == SMC_IDLE) begin
      to_cnt_reg <= 16'h0000;
    end else if (clk_rise && !to_rsp_hit && !to_rd_hit) begin
      to_cnt_reg <= to_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_seen_reg <= 1'b0;
    end else if (state_reg != SMC_BUSY) begin
      busy_seen_reg <= 1'b0;
    end else if (card_busy_in) begin
      busy_seen_reg <= 1'b1;
    end
  end

  // Status read clears; a simultaneous new event still lands
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (status_reg_a_rd ? '0 : flags_reg) | flags_set;
      if (rx_data_rd && !flags_set[ST_RX_RDY]) begin
        flags_reg[ST_RX_RDY] <= 1'b0;
      end
    end
  end

  // Staging of the byte-enabled transmit word
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_be_reg   <= 4'h0;
      pend_data_reg <= 32'h0000_0000;
    end else if (data_rst) begin
      pend_be_reg   <= 4'h0;
    end else if (tx_data_wr && !lane_valid) begin
      pend_be_reg   <= tx_data_be;
      pend_data_reg <= tx_data_reg;
    end else if (cpu_push) begin
      pend_be_reg[lane_sel] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= FIFO_CNT_RST;
      wptr_reg  <= '0;
      rptr_reg  <= '0;
    end else if (data_rst) begin
      count_reg <= FIFO_CNT_RST;
      wptr_reg  <= '0;
      rptr_reg  <= '0;
    end else begin
      count_reg <= count_reg + 7'(push) - 7'(pop);
      if (push) wptr_reg <= wptr_reg + 1'b1;
      if (pop)  rptr_reg <= rptr_reg + 1'b1;
    end
  end

  // Block byte and block counters
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_cnt_reg <= 12'h000;
      blk_left_reg <= BLK_CNT_RST;
    end else if (data_rst || rd_start) begin
      byte_cnt_reg <= 12'h000;
      blk_left_reg <= block_count_reg;
    end else if (blk_end) begin
      byte_cnt_reg <= 12'h000;
      if (blk_left_reg != 16'h0000) blk_left_reg <= blk_left_reg - 16'h1;
    end else if (card_push) begin
      byte_cnt_reg <= byte_cnt_reg + 12'h001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      card_clock_pin <= 1'b0;
      card_bus_4bit  <= 1'b0;
      card_byte_out  <= 8'h00;
      tx_ready_irq   <= 1'b0;
      status_reg_a   <= '0;
      card_busy_flag <= 1'b0;
      fifo_level     <= 7'h00;
      blocks_left    <= 16'h0000;
      xfer_active    <= 1'b0;
      mmc_irq        <= 1'b0;
    end else begin
      card_clock_pin <= div_clk;
      card_bus_4bit  <= bus_width_4;
      card_byte_out  <= mem_rdata;
      tx_ready_irq   <= flags_reg[ST_TX_RDY]
                        && interrupt_mask_reg[ST_TX_RDY];
      status_reg_a   <= flags_reg;
      card_busy_flag <= card_busy_in;
      fifo_level     <= count_reg;
      blocks_left    <= blk_left_reg;
      xfer_active    <= any_xfer;
      mmc_irq        <= |(flags_reg & interrupt_mask_reg);
    end
  end
endmodule

// *** sim/smc_ctrl_sva.sv ***
// Assertion checker for the card host control and status block
`timescale 1ns/100ps
module smc_ctrl_sva (
  input wire logic                      clk,
  input wire logic                      reset_n,
  input wire logic                      soft_reset,
  input wire logic                      cmd_logic_reset,
  input wire logic                      data_logic_reset,
  input wire logic                      bus_width_4,
  input wire logic                      card_clock_out_enable,
  input wire logic [smc_pkg::ST_W-1:0]  interrupt_mask_reg,
  input wire logic [6:0]                fifo_threshold_level,
  input wire logic                      fifo_dir_write,
  input wire logic                      status_reg_a_rd,
  input wire logic                      rsp_crc_err,
  input wire logic                      rd_crc_err,
  input wire logic                      wr_crc_err,
  input wire logic                      card_busy_in,
  input wire logic                      card_clock_pin,
  input wire logic                      card_bus_4bit,
  input wire logic [smc_pkg::ST_W-1:0]  status_reg_a,
  input wire logic                      card_busy_flag,
  input wire logic [6:0]                fifo_level,
  input wire logic                      xfer_active,
  input wire logic                      mmc_irq
);
  import smc_pkg::*;
  wire ok = !soft_reset && !cmd_logic_reset && !data_logic_reset;
  wire quiet = !(rsp_crc_err || rd_crc_err || wr_crc_err);
  wire [ST_W-1:0] hit = status_reg_a & interrupt_mask_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  rsp_crc_a: assert property (
    ok && rsp_crc_err |-> ##[1:3] status_reg_a[ST_CRC_RSP])
    else $error("response crc flag missing");
  wr_crc_a: assert property (
    ok && wr_crc_err |-> ##[1:3] status_reg_a[ST_CRC_WR])
    else $error("write crc flag missing");
  width_follow_a: assert property (
    bus_width_4[*2] |-> card_bus_4bit)
    else $error("bus width not four bits");
  irq_on_a: assert property (
    (|hit && $stable(interrupt_mask_reg))[*3] |-> mmc_irq)
    else $error("interrupt missing");
  irq_masked_a: assert property (
    (~|hit)[*3] |-> !mmc_irq)
    else $error("masked interrupt raised");
  read_clear_a: assert property (
    quiet[*2] ##1 (status_reg_a_rd && quiet) ##1 quiet
      |-> ##1 status_reg_a[ST_CRC_WR:ST_CRC_RSP] == 3'h0)
    else $error("status read left flags set");
  busy_flag_a: assert property (
    card_busy_in[*3] |-> card_busy_flag)
    else $error("card busy flag missing");
  busy_free_a: assert property (
    (!card_busy_in)[*3] |-> !card_busy_flag)
    else $error("card busy flag stuck");
  tx_ready_a: assert property (
    (ok && fifo_dir_write && fifo_level < fifo_threshold_level)[*3]
      |-> status_reg_a[ST_TX_RDY])
    else $error("tx ready flag missing");
  clock_gate_a: assert property (
    (!card_clock_out_enable && !xfer_active)[*4] |-> $stable(card_clock_pin))
    else $error("card clock runs while gated");
endmodule
bind smc_ctrl smc_ctrl_sva smc_ctrl_sva_inst (
  .clk, .reset_n, .soft_reset, .cmd_logic_reset, .data_logic_reset,
  .bus_width_4, .card_clock_out_enable, .interrupt_mask_reg,
  .fifo_threshold_level, .fifo_dir_write, .status_reg_a_rd, .rsp_crc_err,
  .rd_crc_err, .wr_crc_err, .card_busy_in, .card_clock_pin, .card_bus_4bit,
  .status_reg_a, .card_busy_flag, .fifo_level, .xfer_active, .mmc_irq
);

// *** sim/smc_card_model.sv ***
// Behavioural card: busy line and read byte stream
`timescale 1ns/100ps
module smc_card_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       card_clock_pin,
  input  wire logic       hold_busy,
  input  wire logic       stream_on,
  output logic            card_busy_in,
  output logic            card_byte_in_valid,
  output logic [7:0]      card_byte_in
);
  logic       pin_q;
  logic [7:0] next_reg;
  wire rise = card_clock_pin && !pin_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_q <= 1'b0;
      card_busy_in <= 1'b0;
      card_byte_in_valid <= 1'b0;
      card_byte_in <= 8'h00;
      next_reg <= 8'h01;
    end else begin
      pin_q <= card_clock_pin;
      card_busy_in <= hold_busy;
      card_byte_in_valid <= stream_on && rise;
      // Idle data is inverted so a stale byte never looks valid
      card_byte_in <= (stream_on && rise) ? next_reg : ~card_byte_in;
      if (stream_on && rise) begin
        next_reg <= next_reg + 8'h01;
      end
    end
  end
endmodule

// *** sim/tb_smc_ctrl.sv ***
// Self-checking bench for the card host control and status block
`timescale 1ns/100ps
module tb_smc_ctrl;
  import smc_pkg::*;
  typedef struct packed {
    logic [3:0] be;
    logic [6:0] lvl;
  } smc_row_s;
  smc_row_s rows [7] = '{'{4'h1, 7'h01}, '{4'h3, 7'h02}, '{4'h7, 7'h03},
    '{4'hf, 7'h04}, '{4'h4, 7'h01}, '{4'ha, 7'h02}, '{4'hd, 7'h03}};
  logic clk, card_busy_in, card_byte_in_valid, card_clock_pin, pin_q;
  logic card_bus_4bit, card_busy_flag, mmc_irq, tx_ready_irq;
  logic [15:0] blocks_left;
  logic reset_n = 1'b0, soft_reset = 1'b0, bus_width_4 = 1'b0;
  logic cmd_logic_reset = 1'b1, data_logic_reset = 1'b1;
  logic card_clock_out_enable = 1'b0, divide_by_four_select = 1'b0;
  logic fifo_dir_write = 1'b1, cmd_needs_rsp = 1'b0;
  logic expect_busy_bit = 1'b0, hold_busy = 1'b0, stream_on = 1'b0;
  logic [7:0] clock_divider_value = 8'h00, response_timeout_reg = 8'h00;
  logic [7:0] card_byte_in, card_byte_out;
  logic [6:0] fifo_threshold_level = 7'h04, fifo_level;
  logic [3:0] tx_data_be = 4'h0;
  logic [ST_W-1:0] interrupt_mask_reg = 10'h000, status_reg_a;
  logic [11:0] ev = 12'h000;
  int fails, total_checks, cyc, rises, r0;
  smc_ctrl smc_ctrl_inst (
    .clk, .reset_n, .soft_reset, .cmd_logic_reset, .data_logic_reset,
    .bus_width_4, .card_clock_out_enable, .clock_divider_value,
    .divide_by_four_select, .interrupt_mask_reg, .response_timeout_reg,
    .read_data_timeout_reg(16'h0000), .block_length_reg(12'h200),
    .block_count_reg(16'h0001), .fifo_threshold_level, .fifo_dir_write,
    .tx_data_wr(ev[10]), .tx_data_be, .tx_data_reg(32'h44332211),
    .rx_data_rd(ev[8]), .status_reg_a_rd(ev[7]), .cmd_start(ev[3]),
    .cmd_needs_rsp, .expect_busy_bit, .cmd_sent(ev[4]),
    .rsp_received(ev[5]), .rsp_crc_err(ev[0]), .rd_start(ev[6]),
    .rd_first_data(ev[11]), .rd_crc_err(ev[1]), .wr_crc_err(ev[2]),
    .card_byte_in_valid, .card_byte_in, .card_byte_out_take(ev[9]),
    .card_busy_in, .stop_transmission(1'b0), .card_clock_pin,
    .card_bus_4bit, .card_byte_out, .tx_ready_irq, .status_reg_a,
    .card_busy_flag, .fifo_level, .blocks_left, .xfer_active(), .mmc_irq
  );
  smc_card_model smc_card_model_inst (.clk, .reset_n, .card_clock_pin,
    .hold_busy, .stream_on, .card_busy_in, .card_byte_in_valid,
    .card_byte_in);
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    ev <= 12'h001 << b;
    @(posedge clk);
    ev <= 12'h000;
  endtask
  task automatic rd_st;
    pulse(7);
    wt(3);
  endtask
  task automatic wr_tx(input logic [3:0] be);
    @(posedge clk);
    tx_data_be <= be;
    ev <= 12'h400;
    @(posedge clk);
    ev <= 12'h000;
    wt(8);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Rising edges of the card clock, and the hang limit
  always @(posedge clk) begin
    pin_q <= card_clock_pin;
    cyc <= cyc + 1;
    if (card_clock_pin && !pin_q) begin
      rises <= rises + 1;
    end
    if (cyc == 12000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    check({status_reg_a, mmc_irq, card_bus_4bit, fifo_level}, 0);
    reset_n <= 1'b1;
    @(posedge clk);
    clock_divider_value <= 8'h1f;
    divide_by_four_select <= 1'b1;
    @(posedge clk);
    cmd_logic_reset <= 1'b0;
    data_logic_reset <= 1'b0;
    @(posedge clk);
    card_clock_out_enable <= 1'b1;
    wt(4);
    r0 = rises;
    wt(1280);
    check(rises - r0, 10);
    @(posedge clk);
    clock_divider_value <= 8'h00;
    divide_by_four_select <= 1'b0;
    wt(4);
    r0 = rises;
    wt(100);
    check(rises - r0, 50);
    @(posedge clk);
    card_clock_out_enable <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clk);
      data_logic_reset <= 1'b1;
      @(posedge clk);
      data_logic_reset <= 1'b0;
      wr_tx(rows[i].be); // Prefill ahead of any command
      check(fifo_level, rows[i].lvl);
      rd_st();
      check(status_reg_a[ST_TX_RDY], rows[i].lvl < 7'h04);
      for (int l = 0; l < 4; l++) begin
        if (rows[i].be[l]) begin
          check(card_byte_out, 8'h11 * (l + 1));
          pulse(9);
          wt(3);
        end
      end
      $display("row %0d done", i);
    end
    @(posedge clk);
    data_logic_reset <= 1'b1;
    wr_tx(4'hf);
    check(fifo_level, 7'h00);
    @(posedge clk);
    data_logic_reset <= 1'b0;
    bus_width_4 <= 1'b1;
    wr_tx(4'h3);
    @(posedge clk);
    soft_reset <= 1'b1;
    wt(3);
    @(posedge clk);
    soft_reset <= 1'b0;
    wt(3);
    check(card_bus_4bit, 1'b1);
    check(fifo_level, 7'h02);
    @(posedge clk);
    interrupt_mask_reg <= 10'h001;
    wt(3);
    check(tx_ready_irq, 1'b1);
    check(mmc_irq, 1'b1);
    $display("resets done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      interrupt_mask_reg <= (i == 1) ? 10'h000 : 10'h004 << i;
      rd_st();
      pulse(i);
      wt(3);
      check(status_reg_a[4:2], 3'h1 << i);
      check(mmc_irq, i != 1);
    end
    rd_st();
    check(status_reg_a[7:2], 6'h00);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      cmd_needs_rsp <= (k == 1);
      rd_st();
      pulse(3);
      pulse(4);
      wt(3);
      check(status_reg_a[ST_RSP_DONE], k == 0);
      pulse(5);
      wt(3);
      check(status_reg_a[ST_RSP_DONE], 1'b1);
    end
    $display("flags done");
    pulse(3);
    pulse(4);
    wt(200);
    check(status_reg_a[ST_TO_RSP], 1'b0);
    pulse(5);
    @(posedge clk);
    response_timeout_reg <= 8'h05;
    rd_st();
    pulse(3);
    pulse(4);
    wt(4);
    check(status_reg_a[ST_TO_RSP], 1'b0);
    wt(30);
    check(status_reg_a[ST_TO_RSP], 1'b1);
    @(posedge clk);
    response_timeout_reg <= 8'h00;
    hold_busy <= 1'b1;
    expect_busy_bit <= 1'b1;
    pulse(3);
    pulse(4);
    pulse(5);
    wt(4);
    rd_st();
    check(card_busy_flag, 1'b1);
    check(status_reg_a[ST_BSY_DONE], 1'b0);
    @(posedge clk);
    hold_busy <= 1'b0;
    wt(6);
    check(card_busy_flag, 1'b0);
    check(status_reg_a[ST_BSY_DONE], 1'b1);
    $display("busy done");
    @(posedge clk);
    fifo_dir_write <= 1'b0;
    data_logic_reset <= 1'b1;
    @(posedge clk);
    data_logic_reset <= 1'b0;
    stream_on <= 1'b1;
    pulse(6);
    pulse(11);
    wt(30);
    check(status_reg_a[ST_RX_RDY], 1'b1);
    check(blocks_left, 16'h0001);
    pulse(8);
    $display("receive done");
    give_verdict();
  end
endmodule
